// [tdm_frame_irq_timing_status.sv]
// Frame and superframe interrupt timing and channel configuration status.
// Assumes one clock, a synchronous register port and event pulses from the transfer engine.
//
// Functional notes
// - Bits 15-14 of the transmit delay register pick the transmit superframe interrupt trigger.
// - Bits 13-12 of the transmit delay register pick the transmit frame trigger.
// - Bits 15-14 of the receive delay register pick the receive superframe trigger.
// - Bits 13-12 of the receive delay register pick the receive frame trigger.
// - Code 10 fires the interrupt on each acknowledge and again on each delay expiry.
// - Code 11 fires the interrupt once both acknowledge and delay expiry have occurred.
// - A delay value n expires n plus one timeslots after the frame goes pending.
// - The transmit delay is seven writable bits that reset to 0x7f.
// - The receive delay is seven writable bits that reset to 0x7f.
// - Transmit channel k reports its configuration state in bits 2k+1 to 2k.
// - Receive channels report their state with the same bit placement.
// - A state of 00 means no configuration is active and 11 is never reported.
// - A state of 01 means the A configuration is active.
// - A state of 10 means the B configuration is active.
// - A channel takes its requested A or B set at the next superframe sync.
`timescale 1ns/1ps
`include "tdm_irq_consts.svh"
module tdm_frame_irq_timing_status (
	// Clock, reset, enable
	input wire logic ref_clk_i,
	input wire logic srst_i,
	input wire logic clk_en_i,
	// Register port
	input wire tdm_irq_pkg::reg_req_type reg_req_i,
	output logic [31:0] reg_rdata_o,
	// Engine events
	input wire tdm_irq_pkg::dir_evt_type tx_evt_i,
	input wire tdm_irq_pkg::dir_evt_type rx_evt_i,
	input wire logic slot_tick_i,
	input wire logic sf_sync_i,
	// Interrupt pulses
	output logic tx_frame_irq_o,
	output logic tx_superframe_irq_o,
	output logic rx_frame_irq_o,
	output logic rx_superframe_irq_o
);
	import tdm_irq_pkg::*;

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		irq_sel_type tx_sf_sel;
		irq_sel_type tx_fr_sel;
		logic [6:0] tx_dly;
		irq_sel_type rx_sf_sel;
		irq_sel_type rx_fr_sel;
		logic [6:0] rx_dly;
		logic [`CH_DIR_W*2-1:0] req;
		logic [`CH_DIR_W*2-1:0] enb;
		logic [`CH_DIR_W*2-1:0] cs;
		dir_state_type tx;
		dir_state_type rx;
		logic [31:0] rdata;
		logic [3:0] irq;
	} state_type;

	state_type cur_ff;
	state_type nxt_cur;
	logic [`CH_DIR_W*2-1:0] sync_cs;

	// ****************************************
	// Channel state at superframe sync
	// ****************************************
	// Only 00, 01 or 10 can be produced, so the reserved code never reaches software.
	for (genvar g = 0; g < `NUM_CHAN * 2; g++) begin : g_chan
		assign sync_cs[2*g +: 2] = !cur_ff.enb[2*g] ? `CS_NONE :
			cur_ff.req[2*g] ? `CS_B :
			`CS_A;
	end

	// One direction's trigger logic; returns the new state and sets fire bits.
	function automatic dir_state_type step_dir(input dir_state_type s, input dir_evt_type e,
			input irq_sel_type sel, input logic [6:0] dly, input logic tick,
			output logic fire);
		dir_state_type n;
		logic expire;
		logic ack;
		n = s;
		fire = 1'b0;
		expire = 1'b0;
		ack = e.xfer_ack;
		if (e.frame_pend) begin
			// A new pending frame restarts the count and forgets old events.
			n.dly_run = 1'b1;
			n.dly_cnt = dly;
			n.dly_seen = 1'b0;
			n.xfer_seen = 1'b0;
			n.sf_flag = e.sf_frame;
		end else if (s.dly_run && tick) begin
			// n+1 ticks: the tick that finds zero is the expiry.
			if (s.dly_cnt == 7'h00) begin
				expire = 1'b1;
				n.dly_run = 1'b0;
			end else begin
				n.dly_cnt = s.dly_cnt - 7'h01;
			end
		end
		unique case (sel)
			2'b00: fire = ack;
			2'b01: fire = expire;
			2'b10: fire = ack | expire;
			2'b11: begin
				// A new pending frame has already cleared the recorded events in n.
				fire = (ack | n.xfer_seen) & (expire | n.dly_seen);
				if (fire) begin
					n.xfer_seen = 1'b0;
					n.dly_seen = 1'b0;
				end else begin
					n.xfer_seen = n.xfer_seen | ack;
					n.dly_seen = n.dly_seen | expire;
				end
			end
		endcase
		return n;
	endfunction

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic txf;
		logic rxf;
		logic txs;
		logic rxs;
		logic [3:0] fires;
		logic [`CH_DIR_W*2-1:0] ncs;
		txf = 1'b0;
		rxf = 1'b0;
		txs = 1'b0;
		rxs = 1'b0;
		fires = 4'h0;
		ncs = cur_ff.cs;
		nxt_cur = cur_ff;
		// Frame triggers use the frame field unless the pending frame ends a superframe.
		nxt_cur.tx = step_dir(cur_ff.tx, tx_evt_i,
			tx_evt_i.frame_pend ? (tx_evt_i.sf_frame ? cur_ff.tx_sf_sel : cur_ff.tx_fr_sel)
			: (cur_ff.tx.sf_flag ? cur_ff.tx_sf_sel : cur_ff.tx_fr_sel),
			cur_ff.tx_dly, slot_tick_i, txf);
		nxt_cur.rx = step_dir(cur_ff.rx, rx_evt_i,
			rx_evt_i.frame_pend ? (rx_evt_i.sf_frame ? cur_ff.rx_sf_sel : cur_ff.rx_fr_sel)
			: (cur_ff.rx.sf_flag ? cur_ff.rx_sf_sel : cur_ff.rx_fr_sel),
			cur_ff.rx_dly, slot_tick_i, rxf);
		txs = txf & (tx_evt_i.frame_pend ? tx_evt_i.sf_frame : cur_ff.tx.sf_flag);
		rxs = rxf & (rx_evt_i.frame_pend ? rx_evt_i.sf_frame : cur_ff.rx.sf_flag);
		fires = {rxs, rxf & ~rxs, txs, txf & ~txs};
		nxt_cur.irq = fires;
		// Channel state: only 00, 01 or 10 is ever loaded.
		if (sf_sync_i) begin
			ncs = sync_cs;
		end
		nxt_cur.cs = ncs;
		if (reg_req_i.wr) begin
			unique case (reg_req_i.addr)
				`OFS_TX_DELAY: begin
					nxt_cur.tx_sf_sel = reg_req_i.wdata[`SF_SEL_HI:`SF_SEL_LO];
					nxt_cur.tx_fr_sel = reg_req_i.wdata[`FR_SEL_HI:`FR_SEL_LO];
					nxt_cur.tx_dly = reg_req_i.wdata[`DLY_HI:`DLY_LO];
				end
				`OFS_RX_DELAY: begin
					nxt_cur.rx_sf_sel = reg_req_i.wdata[`SF_SEL_HI:`SF_SEL_LO];
					nxt_cur.rx_fr_sel = reg_req_i.wdata[`FR_SEL_HI:`FR_SEL_LO];
					nxt_cur.rx_dly = reg_req_i.wdata[`DLY_HI:`DLY_LO];
				end
				`OFS_CH_REQUEST: nxt_cur.req = reg_req_i.wdata[`CH_DIR_W*2-1:0];
				`OFS_CH_ENABLE: nxt_cur.enb = reg_req_i.wdata[`CH_DIR_W*2-1:0];
				default: ;
			endcase
		end
		nxt_cur.rdata = 32'h0000_0000;
		if (reg_req_i.rd) begin
			unique case (reg_req_i.addr)
				`OFS_TX_DELAY: nxt_cur.rdata = {16'h0000, cur_ff.tx_sf_sel, cur_ff.tx_fr_sel,
					5'h00, cur_ff.tx_dly};
				`OFS_RX_DELAY: nxt_cur.rdata = {16'h0000, cur_ff.rx_sf_sel, cur_ff.rx_fr_sel,
					5'h00, cur_ff.rx_dly};
				`OFS_TX_STATE: nxt_cur.rdata = {20'h00000, cur_ff.cs[`CH_DIR_W-1:0]};
				`OFS_RX_STATE: nxt_cur.rdata = {20'h00000,
					cur_ff.cs[`RX_HALF +: `CH_DIR_W]};
				`OFS_CH_REQUEST: nxt_cur.rdata = {8'h00, cur_ff.req};
				`OFS_CH_ENABLE: nxt_cur.rdata = {8'h00, cur_ff.enb};
				default: nxt_cur.rdata = 32'h0000_0000;
			endcase
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			cur_ff <= '0;
			cur_ff.tx_dly <= `DLY_RESET;
			cur_ff.rx_dly <= `DLY_RESET;
			cur_ff.tx_sf_sel <= `SEL_RESET;
			cur_ff.tx_fr_sel <= `SEL_RESET;
			cur_ff.rx_sf_sel <= `SEL_RESET;
			cur_ff.rx_fr_sel <= `SEL_RESET;
		end else if (clk_en_i) begin
			cur_ff <= nxt_cur;
		end
	end

	assign reg_rdata_o = cur_ff.rdata;
	assign tx_frame_irq_o = cur_ff.irq[0];
	assign tx_superframe_irq_o = cur_ff.irq[1];
	assign rx_frame_irq_o = cur_ff.irq[2];
	assign rx_superframe_irq_o = cur_ff.irq[3];
endmodule

// [tdm_irq_consts.svh]
// Constants for the frame and superframe interrupt timing block.
// Assumes inclusion by bare name from the package and the design file.
`ifndef TDM_IRQ_CONSTS_SVH
`define TDM_IRQ_CONSTS_SVH
`define ADDR_W 12
`define OFS_TX_DELAY 12'h184
`define OFS_RX_DELAY 12'h188
`define OFS_TX_STATE 12'h190
`define OFS_RX_STATE 12'h194
`define OFS_CH_REQUEST 12'h198
`define OFS_CH_ENABLE 12'h19c
`define SF_SEL_HI 15
`define SF_SEL_LO 14
`define FR_SEL_HI 13
`define FR_SEL_LO 12
`define DLY_HI 6
`define DLY_LO 0
`define DLY_RESET 7'h7f
`define SEL_RESET 2'h0
`define CS_NONE 2'h0
`define CS_A 2'h1
`define CS_B 2'h2
`define NUM_CHAN 6
`define CH_DIR_W 12
`define RX_HALF 12
`endif

// [tdm_irq_pkg.sv]
// Types shared by the frame interrupt timing block.
// Assumes the constants header sits in the same folder.
`include "tdm_irq_consts.svh"
package tdm_irq_pkg;
	typedef logic [1:0] irq_sel_type;
	typedef struct packed {
		logic [`ADDR_W-1:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} reg_req_type;
	// Per-direction events from the transfer engine.
	typedef struct packed {
		logic xfer_ack;
		logic frame_pend;
		logic sf_frame;
	} dir_evt_type;
	typedef struct packed {
		logic xfer_seen;
		logic dly_seen;
		logic dly_run;
		logic [6:0] dly_cnt;
		logic sf_flag;
	} dir_state_type;
endpackage

// [irq_ctrl_model.sv]
// Host interrupt controller model: keeps the first interrupt seen after a clear.
// Assumes one-cycle interrupt pulses sampled on the rising edge.
`timescale 1ns/1ps
module irq_ctrl_model (
	input wire logic clk_i,
	input wire logic clr_i,
	input wire logic [3:0] irq_i,
	output logic [3:0] seen_o,
	output int when_o
);
	int cyc;
	always @(posedge clk_i) begin
		cyc <= clr_i ? 0 : cyc + 1;
		seen_o <= clr_i ? 4'h0 : seen_o != 4'h0 ? seen_o : irq_i;
		when_o <= clr_i ? -1 : seen_o == 4'h0 && irq_i != 4'h0 ? cyc : when_o;
	end
endmodule

// [tdm_irq_chk.sv]
// Assertions on the frame interrupt block ports.
// Assumes clk_en_i held high; mirrors the transmit delay register.
`timescale 1ns/1ps
`include "tdm_irq_consts.svh"
module tdm_irq_chk import tdm_irq_pkg::*; (
	input wire logic ref_clk_i,
	input wire logic srst_i,
	input wire tdm_irq_pkg::reg_req_type reg_req_i,
	input wire logic [31:0] reg_rdata_o,
	input wire tdm_irq_pkg::dir_evt_type tx_evt_i,
	input wire logic slot_tick_i,
	input wire logic tx_frame_irq_o
);
	logic [15:0] txr_ff;
	always_ff @(posedge ref_clk_i) begin
		if (srst_i || reg_req_i.wr && reg_req_i.addr == `OFS_TX_DELAY) begin
			txr_ff <= srst_i ? 16'h7f : reg_req_i.wdata[15:0] & 16'hf07f;
		end
	end
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (srst_i);
	sequence ack_pend;
		tx_evt_i.frame_pend && tx_evt_i.xfer_ack && !tx_evt_i.sf_frame && txr_ff[13:12] == 2'h0;
	endsequence
	sequence pend_tick;
		tx_evt_i.frame_pend && !tx_evt_i.sf_frame && txr_ff[13:0] == 14'h1000
		##1 slot_tick_i && !tx_evt_i.frame_pend;
	endsequence
	rst_quiet_a: assert property (disable iff (1'b0)
		srst_i |=> !tx_frame_irq_o && reg_rdata_o == 0) else $error("active after reset");
	rdata_idle_a: assert property (!$past(reg_req_i.rd) |-> reg_rdata_o == 0)
		else $error("read data outside slot");
	unmapped_zero_a: assert property (reg_req_i.rd && reg_req_i.addr == 12'h100 |=> reg_rdata_o == 0)
		else $error("unmapped read not zero");
	dly_readback_a: assert property (reg_req_i.rd && reg_req_i.addr == `OFS_TX_DELAY
		|=> reg_rdata_o == {16'h0, txr_ff}) else $error("delay register mismatch");
	state_fields_a: assert property (reg_req_i.rd && reg_req_i.addr[11:3] == 9'h032
		|=> reg_rdata_o[31:12] == 0 && (reg_rdata_o[11:0] & reg_rdata_o[11:0] >> 1 & 12'h555) == 0)
		else $error("bad channel state");
	ack_fire_a: assert property (ack_pend |=> tx_frame_irq_o) else $error("ack missed");
	dly_expiry_a: assert property (pend_tick |=> tx_frame_irq_o) else $error("expiry missed");
	irq_cause_a: assert property (tx_frame_irq_o |-> $past(tx_evt_i.xfer_ack || slot_tick_i))
		else $error("interrupt without cause");
endmodule
bind tdm_frame_irq_timing_status tdm_irq_chk tdm_irq_chk_i (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
	.reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o), .tx_evt_i(tx_evt_i),
	.slot_tick_i(slot_tick_i), .tx_frame_irq_o(tx_frame_irq_o));

// [tb.sv]
// Bench: register and event stimulus checked against a bench model.
// Assumes the design, its package, the checker and the interrupt controller model.
`timescale 1ns/1ps
`include "tdm_irq_consts.svh"
module tb;
	import tdm_irq_pkg::*;
	logic clk = 1'b0, srst = 1'b1, tick = 1'b0, sync = 1'b0, clr = 1'b0;
	reg_req_type req = '0;
	dir_evt_type ev, tev = '0, rev = '0;
	logic [31:0] rdata, q, en, s;
	logic [3:0] irq, seen;
	int when, d, sf, m, n, a, k, error_cnt = 0, checked = 0;
	always #12.5 clk = ~clk;
	tdm_frame_irq_timing_status tdm_frame_irq_timing_status_i (.ref_clk_i(clk), .srst_i(srst),
		.clk_en_i(1'b1), .reg_req_i(req), .reg_rdata_o(rdata), .tx_evt_i(tev), .rx_evt_i(rev),
		.slot_tick_i(tick), .sf_sync_i(sync), .tx_frame_irq_o(irq[0]), .tx_superframe_irq_o(irq[1]),
		.rx_frame_irq_o(irq[2]), .rx_superframe_irq_o(irq[3]));
	irq_ctrl_model irq_ctrl_model_i (.clk_i(clk), .clr_i(clr), .irq_i(irq), .seen_o(seen),
		.when_o(when));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) error_cnt++;
		if (got !== exp) $display("wrong value at %0t: got %h expected %h", $time, got, exp);
	endtask
	task acc(input logic w, input logic [11:0] ad, input logic [31:0] dt);
		@(posedge clk) req <= '{ad, w ? dt : 32'h0, w, !w};
		@(posedge clk) req <= '0;
		@(negedge clk) if (!w) chk(rdata, dt);
	endtask
	task wrap_up;
		$display("comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		void'($urandom(32'hbf35));
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		acc(0, `OFS_TX_DELAY, 32'h7f);
		acc(0, `OFS_RX_DELAY, 32'h7f);
		acc(0, 12'h100, 32'h0);
		// An early frame pend, and a tick when the delay is nonzero, precede each run, so a count that fails to restart fires early.
		for (int i = 0; i < 16; i++) begin
			d = i / 8;
			sf = i / 4 % 2;
			m = i % 4;
			n = m == 1 ? 0 : $urandom_range(6, 1);
			a = m == 0 ? 0 : $urandom_range(10, 1);
			acc(1, d ? `OFS_RX_DELAY : `OFS_TX_DELAY, m << (sf ? 14 : 12) | n);
			acc(0, d ? `OFS_RX_DELAY : `OFS_TX_DELAY, m << (sf ? 14 : 12) | n);
			for (int c = -2; c < 14; c++) begin
				ev = '{c == a, c == 0 || c == -2, sf[0]};
				@(posedge clk) {tev, rev, clr} <= {d ? 3'h0 : ev, d ? ev : 3'h0, c == 0};
				tick <= c == -1 && n > 0 || c > 0 && c <= n + 1;
			end
			k = m == 1 || m == 3 && a < n + 1 || m == 2 && a > n + 1 ? n + 1 : a;
			chk(when, k);
			chk(seen, 1 << d * 2 + sf);
		end
		s = 0;
		repeat (3) begin
			q = $urandom;
			en = $urandom;
			acc(1, `OFS_CH_REQUEST, q);
			acc(1, `OFS_CH_ENABLE, en);
			acc(0, `OFS_RX_STATE, s[23:12]);
			for (k = 0; k < 12; k++) s[2*k +: 2] = !en[2*k] ? `CS_NONE : q[2*k] ? `CS_B : `CS_A;
			@(posedge clk) sync <= 1'b1;
			@(posedge clk) sync <= 1'b0;
			acc(0, `OFS_TX_STATE, s[11:0]);
			acc(0, `OFS_RX_STATE, s[23:12]);
		end
		wrap_up();
	end
endmodule
